// [pkg/ibcg_pkg.sv]
// package: register map, field layout and timing constants for the in-band loop code block
package ibcg_pkg;

   // =====================================================
   // register offsets
   localparam logic [7:0] IBCG_ADDR_LENGTH_CTRL = 8'h12;
   localparam logic [7:0] IBCG_ADDR_TX_PATTERN = 8'h13;
   localparam logic [7:0] IBCG_ADDR_UP_PATTERN = 8'h14;
   localparam logic [7:0] IBCG_ADDR_DOWN_PATTERN = 8'h15;
   localparam logic [7:0] IBCG_ADDR_CONTROL_THREE = 8'h30;
   localparam logic [7:0] IBCG_ADDR_STATUS_ONE = 8'h31;

   // =====================================================
   // field positions
   localparam int IBCG_SEND_ENABLE_BIT = 1;
   localparam int IBCG_UP_FLAG_BIT = 7;
   localparam int IBCG_DOWN_FLAG_BIT = 6;
   localparam logic [7:0] IBCG_RESET_VALUE = 8'h00;

   // =====================================================
   // frame and timing
   localparam logic [7:0] IBCG_FRAME_BITS = 8'hC1;   // 193 bits per frame
   localparam int IBCG_CLK_HZ = 20_000_000;
   localparam int IBCG_LINE_HZ = 1_544_000;
   localparam int IBCG_INTEGRATION_MS = 48;
   // bits received in the integration period
   localparam int IBCG_INTEGRATION_BITS = IBCG_LINE_HZ / 1000 * IBCG_INTEGRATION_MS;
   // error tolerance: one bit in a hundred, judged in windows of 128 bits
   localparam logic [7:0] IBCG_WINDOW_BITS = 8'h80;
   localparam logic [7:0] IBCG_WINDOW_ERRORS = 8'h02;

   // detector settings (pattern and length select), bundled per detector
   typedef struct packed {
      logic [7:0] pattern;
      logic [2:0] length_sel;
   } ibcg_det_cfg_type;

endpackage

// [logic/ibcg_core.sv]
// in-band loop code generator and dual detector for one T1 framer
//
// Overview of operation
// - generate and detect repeating 1..8 bit patterns
// - send pattern while send enable is set
// - yield every 193rd bit to framing bit
// - tx length 00=5,01=6,10=7,11=8 bits
// - pattern bit 7 is sent first
// - unused low-order tx pattern bits ignored
// - independent up and down detectors, own settings
// - receive length equals field value plus one
// - length control holds tx, up, down fields
// - detect framed or unframed, tolerate 1e-2 errors
// - flag set after 48 ms continuous code
// - receive bit 7 first, trailing bits ignored
module ibcg_core
   import ibcg_pkg::*;
#(
   parameter int INTEGRATION_BITS = IBCG_INTEGRATION_BITS
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // parallel control port
   input wire logic [7:0] addr_in,
   input wire logic wr_en_in,
   input wire logic [7:0] wr_data_in,
   output logic [7:0] rd_data_out,
   // transmit line side
   input wire logic tx_bit_strobe_in,
   input wire logic tx_payload_in,
   input wire logic tx_frame_bit_in,
   input wire logic tx_frame_slot_in,
   input wire logic tx_fbit_insert_off_in,
   output logic tx_line_bit_out,
   // receive line side
   input wire logic rx_bit_strobe_in,
   input wire logic rx_line_bit_in
);

   // =====================================================
   // registers
   logic [7:0] length_ctrl_q;
   logic [7:0] tx_pattern_q;
   logic [7:0] up_pattern_q;
   logic [7:0] down_pattern_q;
   logic [7:0] control_three_q;
   logic [1:0] detected_q;   // [1] up, [0] down
   logic [7:0] rx_history_q;
   logic [2:0] tx_index_q;
   logic [7:0] frame_count_q;
   logic tx_line_bit_q;

   // number of pattern bits selected by a receive length field
   function automatic logic [3:0] rx_len(input logic [2:0] sel);
      rx_len = {1'b0, sel} + 4'h1;
   endfunction

   // tx length: 00=5, 01=6, 10=7, 11=8; shorter codes repeat inside these
   logic [3:0] tx_len;
   assign tx_len = {2'b00, length_ctrl_q[7:6]} + 4'h5;

   logic send_en;
   assign send_en = control_three_q[IBCG_SEND_ENABLE_BIT];

   // =====================================================
   // control port: write decode and read mux
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         length_ctrl_q <= IBCG_RESET_VALUE;
         tx_pattern_q <= IBCG_RESET_VALUE;
         up_pattern_q <= IBCG_RESET_VALUE;
         down_pattern_q <= IBCG_RESET_VALUE;
         control_three_q <= IBCG_RESET_VALUE;
      end else if (wr_en_in) begin
         if (addr_in == IBCG_ADDR_LENGTH_CTRL) length_ctrl_q <= wr_data_in;
         if (addr_in == IBCG_ADDR_TX_PATTERN) tx_pattern_q <= wr_data_in;
         if (addr_in == IBCG_ADDR_UP_PATTERN) up_pattern_q <= wr_data_in;
         if (addr_in == IBCG_ADDR_DOWN_PATTERN) down_pattern_q <= wr_data_in;
         if (addr_in == IBCG_ADDR_CONTROL_THREE) control_three_q <= wr_data_in;
      end
   end

   // status is live state; unmapped addresses read zero
   always_comb begin
      rd_data_out = 8'h00;
      unique case (addr_in)
         IBCG_ADDR_LENGTH_CTRL: rd_data_out = length_ctrl_q;
         IBCG_ADDR_TX_PATTERN: rd_data_out = tx_pattern_q;
         IBCG_ADDR_UP_PATTERN: rd_data_out = up_pattern_q;
         IBCG_ADDR_DOWN_PATTERN: rd_data_out = down_pattern_q;
         IBCG_ADDR_CONTROL_THREE: rd_data_out = control_three_q;
         IBCG_ADDR_STATUS_ONE: rd_data_out = {detected_q, 6'h00};
         default: rd_data_out = 8'h00;
      endcase
   end

   // =====================================================
   // transmit generator
   logic tx_last_index;
   logic tx_code_bit;
   logic tx_fbit_slot;
   assign tx_last_index = ({1'b0, tx_index_q} == tx_len - 4'h1);
   assign tx_code_bit = tx_pattern_q[3'h7 - tx_index_q];   // msb first
   // framing position from the formatter or from a local 193-bit count; either one marks the slot
   assign tx_fbit_slot = tx_frame_slot_in | (frame_count_q == 8'h00);

   // index restarts whenever sending is off, so next enable begins at bit 7
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in || !send_en) begin
         tx_index_q <= 3'h0;
      end else if (tx_bit_strobe_in) begin
         tx_index_q <= tx_last_index ? 3'h0 : tx_index_q + 3'h1;
      end
   end

   // counts bit times so every 193rd slot is known
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         frame_count_q <= 8'h00;
      end else if (tx_bit_strobe_in) begin
         frame_count_q <= (frame_count_q == IBCG_FRAME_BITS - 8'h01) ? 8'h00
                          : frame_count_q + 8'h01;
      end
   end

   // line mux registered so the output bit is glitch free
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         tx_line_bit_q <= 1'b0;
      end else if (tx_bit_strobe_in) begin
         if (!send_en) tx_line_bit_q <= tx_payload_in;
         else if (tx_fbit_slot && !tx_fbit_insert_off_in) tx_line_bit_q <= tx_frame_bit_in;
         else tx_line_bit_q <= tx_code_bit;
      end
   end
   assign tx_line_bit_out = tx_line_bit_q;

   // =====================================================
   // receive detectors: compare each bit with the bit one period earlier,
   // which checks the period at any phase; the pattern match below tries every rotation
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) rx_history_q <= 8'h00;
      else if (rx_bit_strobe_in) rx_history_q <= {rx_history_q[6:0], rx_line_bit_in};
   end

   ibcg_det_cfg_type det_cfg [2];
   assign det_cfg[1] = '{pattern: up_pattern_q, length_sel: length_ctrl_q[5:3]};
   assign det_cfg[0] = '{pattern: down_pattern_q, length_sel: length_ctrl_q[2:0]};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_det
         logic [3:0] len;
         logic [7:0] masked_hist;
         logic [7:0] masked_pat;
         logic [7:0] len_mask;
         logic period_ok;
         logic rot_ok;
         logic bit_err;
         logic [7:0] win_cnt_q;
         logic [7:0] err_cnt_q;
         logic [31:0] integ_q;
         logic [2:0] rot;
         logic win_end;
         logic over;
         logic flag_q;
         logic [3:0] run_q;
         logic err_evt;
         assign len = rx_len(det_cfg[g].length_sel);
         // top len bits of the pattern; trailing bits ignored
         assign len_mask = 8'hFF << (4'h8 - len);
         // newest len bits, left aligned as they were received
         assign masked_hist = (rx_history_q << (4'h8 - len)) & len_mask;
         assign masked_pat = det_cfg[g].pattern & len_mask;
         // periodicity: the incoming bit equals the bit len positions back
         assign period_ok = (len == 4'h8) ? (rx_history_q[7] == rx_line_bit_in)
                            : (rx_history_q[len[2:0] - 3'h1] == rx_line_bit_in);
         // last len bits must be some rotation of the pattern
         always_comb begin
            rot_ok = 1'b0;
            for (int r = 0; r < 8; r++) begin
               rot = r[2:0];
               if ({1'b0, rot} < len && masked_hist ==
                   ((((masked_pat << rot) | (masked_pat >> (len - {1'b0, rot}))))
                    & len_mask)) rot_ok = 1'b1;
            end
         end
         assign bit_err = !(period_ok && rot_ok);
         assign win_end = (win_cnt_q == IBCG_WINDOW_BITS - 8'h01);
         // one line error upsets up to len+1 compares in a row; count it once, and
         // count a lasting mismatch again each time the run counter wraps
         assign err_evt = bit_err && (run_q == 4'h0);
         assign over = (err_cnt_q + {7'h00, err_evt}) > IBCG_WINDOW_ERRORS;

         // length of the current run of failed compares
         always_ff @(posedge clk_sys_in) begin
            if (!reset_n_in) run_q <= 4'h0;
            else if (rx_bit_strobe_in) run_q <= bit_err ? run_q + 4'h1 : 4'h0;
         end

         // windowed error count; excess errors clear the integration
         always_ff @(posedge clk_sys_in) begin
            if (!reset_n_in) begin
               win_cnt_q <= 8'h00;
               err_cnt_q <= 8'h00;
               integ_q <= 32'h0000_0000;
            end else if (rx_bit_strobe_in) begin
               win_cnt_q <= win_end ? 8'h00 : win_cnt_q + 8'h01;
               err_cnt_q <= (win_end || over) ? 8'h00 : err_cnt_q + {7'h00, err_evt};
               if (over) integ_q <= 32'h0000_0000;
               else if (integ_q < INTEGRATION_BITS) integ_q <= integ_q + 32'h0000_0001;
            end
         end

         // flag follows continuous presence after the integration period
         always_ff @(posedge clk_sys_in) begin
            if (!reset_n_in) flag_q <= 1'b0;
            else flag_q <= (integ_q >= INTEGRATION_BITS);
         end
         assign detected_q[g] = flag_q;
      end
   endgenerate

   // =====================================================
   // checks
   tx_disabled_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (tx_bit_strobe_in && !send_en) |=> tx_line_bit_out == $past(tx_payload_in))
      else $error("payload not passed while sending is off");
   tx_fbit_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (tx_bit_strobe_in && send_en && tx_fbit_slot && !tx_fbit_insert_off_in)
      |=> tx_line_bit_out == $past(tx_frame_bit_in))
      else $error("framing bit not inserted");
   tx_code_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (tx_bit_strobe_in && send_en && !tx_fbit_slot) |=> tx_line_bit_out == $past(tx_code_bit))
      else $error("pattern bit not sent");
   tx_restart_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      !send_en |=> tx_index_q == 3'h0 || send_en)
      else $error("generator not restarted");
   tx_wrap_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      ({1'b0, tx_index_q} < tx_len || $changed(length_ctrl_q)))
      else $error("tx index beyond length");
   up_flag_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      $rose(detected_q[1]) |-> $past(gen_det[1].integ_q) >= INTEGRATION_BITS)
      else $error("up flag set early");
   down_clear_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (rx_bit_strobe_in && gen_det[0].over) |=> ##1 !detected_q[0])
      else $error("down flag held through errors");
   status_read_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      addr_in == IBCG_ADDR_STATUS_ONE |-> rd_data_out[IBCG_UP_FLAG_BIT] == detected_q[1]
      && rd_data_out[IBCG_DOWN_FLAG_BIT] == detected_q[0])
      else $error("status read mismatch");
   cfg_write_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (wr_en_in && addr_in == IBCG_ADDR_LENGTH_CTRL) |=> length_ctrl_q == $past(wr_data_in))
      else $error("length control not written");
   up_seen_c: cover property (@(posedge clk_sys_in) $rose(detected_q[1]));
   down_seen_c: cover property (@(posedge clk_sys_in) $rose(detected_q[0]));
   fbit_c: cover property (@(posedge clk_sys_in) tx_bit_strobe_in && send_en && tx_fbit_slot);

endmodule

// [testbench/ibcg_line_model.sv]
// remote line equipment: sends repeating loop codes, with optional bit errors, toward the framer
module ibcg_line_model (
   // clock
   input wire logic clk_sys_in,
   // code selection from the bench
   input wire logic send_in,
   input wire logic [7:0] pattern_in,
   input wire logic [3:0] len_in,
   input wire logic [7:0] err_every_in,
   // receive line toward the framer
   output logic rx_bit_strobe_out,
   output logic rx_line_bit_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int idx = 0;
   int cnt = 0;
   logic ph = 1'b0;
   logic b = 1'b1;
   initial begin
      rx_bit_strobe_out = 1'b0;
      rx_line_bit_out = 1'b1;
   end
   // one bit every two cycles; between strobes the line shows the inverse so stale bits never pass
   always @(negedge clk_sys_in) begin
      ph = ~ph;
      rx_bit_strobe_out = ph;
      if (ph) begin
         cnt = cnt + 1;
         idx = (idx + 1 >= int'(len_in)) ? 0 : idx + 1;
         // idle traffic has a period of 32, so it never looks like a short code
         b = send_in ? pattern_in[7 - idx] : (cnt[0] ^ cnt[2] ^ cnt[4]);
         if (send_in && err_every_in != 8'h00 && cnt % int'(err_every_in) == 0) begin
            b = ~b;
         end
      end
      rx_line_bit_out = ph ? b : ~b;
   end
endmodule

// [testbench/ibcg_core_bench.sv]
// testbench: registers, loop code transmit and loop code detection of ibcg_core
module ibcg_core_bench;
   import ibcg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================
   // stimulus and observation
   localparam logic [7:0] TX_PAT = 8'hB7;
   logic clk_sys_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wr_data_in = 8'h00;
   logic wr_en_in = 1'b0;
   logic tx_bit_strobe_in = 1'b0;
   logic tx_payload_in = 1'b0;
   logic tx_frame_bit_in = 1'b0;
   logic tx_frame_slot_in = 1'b0;
   logic tx_fbit_insert_off_in = 1'b1;
   logic send = 1'b0;
   logic [7:0] pattern = 8'h00;
   logic [3:0] len = 4'h5;
   logic [7:0] err_every = 8'h00;
   logic [7:0] rd_data_out;
   logic tx_line_bit_out;
   logic rx_bit_strobe_in;
   logic rx_line_bit_in;
   logic [7:0] regs [6] = '{IBCG_ADDR_LENGTH_CTRL, IBCG_ADDR_TX_PATTERN, IBCG_ADDR_UP_PATTERN,
      IBCG_ADDR_DOWN_PATTERN, IBCG_ADDR_CONTROL_THREE, IBCG_ADDR_STATUS_ONE};
   int err_total = 0;
   int samples_checked = 0;
   always #25 clk_sys_in = ~clk_sys_in;
   // short integration keeps the detection runs brief
   ibcg_core #(.INTEGRATION_BITS(64)) ibcg_core_i (.clk_sys_in, .reset_n_in, .addr_in,
      .wr_en_in, .wr_data_in, .rd_data_out, .tx_bit_strobe_in, .tx_payload_in,
      .tx_frame_bit_in, .tx_frame_slot_in, .tx_fbit_insert_off_in, .tx_line_bit_out,
      .rx_bit_strobe_in, .rx_line_bit_in);
   ibcg_line_model ibcg_line_model_i (.clk_sys_in, .send_in(send), .pattern_in(pattern),
      .len_in(len), .err_every_in(err_every), .rx_bit_strobe_out(rx_bit_strobe_in),
      .rx_line_bit_out(rx_line_bit_in));
   // =====================================================
   // tasks
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      addr_in = a;
      wr_data_in = d;
      wr_en_in = 1'b1;
      @(negedge clk_sys_in);
      wr_en_in = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_sys_in);
      addr_in = a;
      #5 check(rd_data_out, exp);
   endtask
   // one transmit bit time; the line bit is looked at once the register has moved
   task automatic tx(input logic slot, input logic exp);
      @(negedge clk_sys_in);
      tx_frame_slot_in = slot;
      tx_bit_strobe_in = 1'b1;
      @(negedge clk_sys_in);
      tx_bit_strobe_in = 1'b0;
      tx_frame_slot_in = 1'b0;
      @(negedge clk_sys_in);
      check({7'h00, tx_line_bit_out}, {7'h00, exp});
   endtask
   // status poll with a bounded wait, as host software would do
   task automatic poll(input logic [7:0] exp, input int limit);
      int k;
      k = 0;
      do begin
         @(negedge clk_sys_in);
         addr_in = IBCG_ADDR_STATUS_ONE;
         k++;
         #5;
      end while (rd_data_out !== exp && k < limit);
      check(rd_data_out, exp);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // =====================================================
   // sequence
   initial begin
      repeat (8) @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      foreach (regs[i]) rd(regs[i], IBCG_RESET_VALUE);
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      wr(IBCG_ADDR_STATUS_ONE, 8'hFF);
      rd(IBCG_ADDR_STATUS_ONE, 8'h00);
      wr(IBCG_ADDR_UP_PATTERN, 8'h87);
      rd(IBCG_ADDR_UP_PATTERN, 8'h87);
      wr(IBCG_ADDR_DOWN_PATTERN, 8'hDF);
      rd(IBCG_ADDR_DOWN_PATTERN, 8'hDF);
      wr(IBCG_ADDR_TX_PATTERN, TX_PAT);
      // each length code, junk in unused low bits, restart from bit 7 at every enable
      for (int f = 0; f < 4; f++) begin
         wr(IBCG_ADDR_LENGTH_CTRL, {f[1:0], 6'h22});
         rd(IBCG_ADDR_LENGTH_CTRL, {f[1:0], 6'h22});
         wr(IBCG_ADDR_CONTROL_THREE, 8'h02);
         for (int i = 0; i < 2 * (f + 5) + 1; i++) tx(1'b0, TX_PAT[7 - i % (f + 5)]);
         wr(IBCG_ADDR_CONTROL_THREE, 8'h00);
         tx_payload_in = f[0];
         tx(1'b0, f[0]);
      end
      // framing slot replaces a bit without delaying the pattern
      tx_fbit_insert_off_in = 1'b0;
      tx_frame_bit_in = 1'b1;
      wr(IBCG_ADDR_CONTROL_THREE, 8'h02);
      tx(1'b0, 1'b1);
      tx(1'b1, 1'b1);
      tx(1'b0, 1'b1);
      tx_fbit_insert_off_in = 1'b1;
      tx_frame_bit_in = 1'b0;
      tx(1'b1, 1'b1);
      wr(IBCG_ADDR_CONTROL_THREE, 8'h00);
      // receive: up code with one error per hundred bits, then down code at another phase
      wr(IBCG_ADDR_LENGTH_CTRL, 8'h22);
      pattern = 8'h87;
      err_every = 8'd100;
      send = 1'b1;
      repeat (80) @(negedge clk_sys_in);
      rd(IBCG_ADDR_STATUS_ONE, 8'h00);
      poll(8'h80, 600);
      pattern = 8'hDF;
      len = 4'h3;
      err_every = 8'h00;
      poll(8'h40, 800);
      err_every = 8'd10;
      poll(8'h00, 800);
      send = 1'b0;
      stop_test();
   end
   // watchdog well beyond the few thousand cycles the sequence needs
   initial begin
      #(50 * 20000);
      err_total++;
      stop_test();
   end
endmodule
